// ==== rtl/irq_bank_pkg.sv ====
// Register map, field layout and reset values of the peripheral interrupt enable bank.
package irq_bank_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  // ----------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE_2 = 8'h00;
  localparam logic [7:0] OFS_ENABLE_3 = 8'h04;
  localparam logic [7:0] OFS_FLAGS_2 = 8'h08;
  localparam logic [7:0] OFS_FLAGS_3 = 8'h0c;
  localparam logic [7:0] OFS_GLOBAL_CTL = 8'h10;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h18;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_COMPARATOR_B = 6;
  localparam int BIT_COMPARATOR_A = 5;
  localparam int BIT_NVM_WRITE_DONE = 4;
  localparam int BIT_SERIAL_COLLISION = 3;
  localparam int BIT_CAPCOMP_B = 0;
  localparam int BIT_CAPCOMP_D = 5;
  localparam int BIT_CAPCOMP_C = 4;
  localparam int BIT_TIMER_F_MATCH = 3;
  localparam int BIT_TIMER_D_MATCH = 1;
  localparam int BIT_GLOBAL_IRQ_EN = 7;
  localparam int BIT_PERIPH_GROUP_IRQ_EN = 6;
  localparam int EVT_FLAG_RAISED = 0;
  localparam int EVT_REQUEST_RAISED = 1;
  localparam int EVT_W = 2;
  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_BANK_2 = 8'hf9;
  localparam logic [7:0] MASK_BANK_3 = 8'h3a;
  localparam logic [7:0] MASK_GLOBAL_CTL = 8'hc0;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] RESET_GLOBAL_CTL = 8'h00;
  localparam logic [1:0] RESET_EVT = 2'h0;
endpackage : irq_bank_pkg

// ==== rtl/flag_bus_if.sv ====
// Bundle between the top and a sticky flag bank.
`timescale 1ns/10ps
interface flag_bus_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] wrData;
  logic wr;
  logic [W-1:0] value;
  modport bank (input set, input wrData, input wr, output value);
  modport user (output set, output wrData, output wr, input value);
endinterface : flag_bus_if

// ==== rtl/sticky_flag_bank.sv ====
// Sticky flags set by hardware and written or cleared by software.
`timescale 1ns/10ps
module sticky_flag_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1,
  parameter logic [W-1:0] RESET_VALUE = '0,
  parameter bit CLEAR_ON_ONE = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  flag_bus_if.bank fb
);
  logic [W-1:0] flags;
  logic [W-1:0] kept;
  logic [W-1:0] next_flags;

  // Software write either loads the bits or clears the ones written as one.
  assign kept = !fb.wr ? flags : (CLEAR_ON_ONE ? (flags & ~fb.wrData) : fb.wrData);
  // A hardware set in the same cycle as a clear wins.
  assign next_flags = (kept | fb.set) & IMPL;
  assign fb.value = flags;

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags <= RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : sticky_flag_bank

// ==== rtl/wb_reg_port.sv ====
// Classic Wishbone slave handshake with one wait state.
`timescale 1ns/10ps
module wb_reg_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  output logic take,
  output logic writeLow
);
  logic ack;

  assign take = cyc_i & stb_i & ~ack;
  assign writeLow = take & we_i & sel_i[0];
  assign ack_o = ack;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= take;
    end
  end
endmodule : wb_reg_port

// ==== rtl/peripheral_irq_enable_bank.sv ====
// Peripheral interrupt enable bank with flags, global gating and a Wishbone register port.
`timescale 1ns/10ps
module peripheral_irq_enable_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [irq_bank_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [irq_bank_pkg::DAT_W-1:0] dat_i,
  output logic [irq_bank_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  input wire logic [irq_bank_pkg::REG_W-1:0] sourceEvents2,
  input wire logic [irq_bank_pkg::REG_W-1:0] sourceEvents3,
  output logic periphIrqReq,
  output logic irq
);
  import irq_bank_pkg::*;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic take;
  logic writeLow;
  logic [REG_W-1:0] wrByte;

  wb_reg_port regPort (
    .mclk(mclk),
    .rst(rst),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .sel_i(sel_i),
    .ack_o(ack_o),
    .take(take),
    .writeLow(writeLow)
  );

  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  assign wrByte = dat_i[REG_W-1:0];

  wire wrEnable2 = writeLow & hit(adr_i, OFS_ENABLE_2);
  wire wrEnable3 = writeLow & hit(adr_i, OFS_ENABLE_3);
  wire wrFlags2 = writeLow & hit(adr_i, OFS_FLAGS_2);
  wire wrFlags3 = writeLow & hit(adr_i, OFS_FLAGS_3);
  wire wrGlobal = writeLow & hit(adr_i, OFS_GLOBAL_CTL);
  wire wrEvtClear = writeLow & hit(adr_i, OFS_EVT_CLEAR);
  wire wrEvtEnable = writeLow & hit(adr_i, OFS_EVT_ENABLE);

  // ----------------------------------------------------------------
  // Enable and control registers
  // ----------------------------------------------------------------
  logic [REG_W-1:0] enable2;
  logic [REG_W-1:0] enable3;
  logic [REG_W-1:0] globalCtl;
  logic [EVT_W-1:0] evtEnable;

  always_ff @(posedge mclk) begin
    if (rst) begin
      enable2 <= RESET_ENABLE;
      enable3 <= RESET_ENABLE;
      globalCtl <= RESET_GLOBAL_CTL;
      evtEnable <= RESET_EVT;
    end else begin
      if (wrEnable2) begin
        enable2 <= wrByte & MASK_BANK_2;
      end
      if (wrEnable3) begin
        enable3 <= wrByte & MASK_BANK_3;
      end
      if (wrGlobal) begin
        globalCtl <= wrByte & MASK_GLOBAL_CTL;
      end
      if (wrEvtEnable) begin
        evtEnable <= wrByte[EVT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Source flags
  // ----------------------------------------------------------------
  flag_bus_if #(.W(REG_W)) flags2Bus ();
  flag_bus_if #(.W(REG_W)) flags3Bus ();

  assign flags2Bus.set = sourceEvents2;
  assign flags2Bus.wr = wrFlags2;
  assign flags2Bus.wrData = wrByte;
  assign flags3Bus.set = sourceEvents3;
  assign flags3Bus.wr = wrFlags3;
  assign flags3Bus.wrData = wrByte;

  sticky_flag_bank #(.W(REG_W), .IMPL(MASK_BANK_2), .RESET_VALUE(RESET_FLAGS)) flags2 (
    .mclk(mclk),
    .rst(rst),
    .fb(flags2Bus.bank)
  );

  sticky_flag_bank #(.W(REG_W), .IMPL(MASK_BANK_3), .RESET_VALUE(RESET_FLAGS)) flags3 (
    .mclk(mclk),
    .rst(rst),
    .fb(flags3Bus.bank)
  );

  // ----------------------------------------------------------------
  // Gating toward the core
  // ----------------------------------------------------------------
  wire oscFailReq = flags2Bus.value[BIT_OSC_FAIL] & enable2[BIT_OSC_FAIL];
  wire compBReq = flags2Bus.value[BIT_COMPARATOR_B] & enable2[BIT_COMPARATOR_B];
  wire compAReq = flags2Bus.value[BIT_COMPARATOR_A] & enable2[BIT_COMPARATOR_A];
  wire nvmReq = flags2Bus.value[BIT_NVM_WRITE_DONE] & enable2[BIT_NVM_WRITE_DONE];
  wire collReq = flags2Bus.value[BIT_SERIAL_COLLISION] & enable2[BIT_SERIAL_COLLISION];
  wire ccpBReq = flags2Bus.value[BIT_CAPCOMP_B] & enable2[BIT_CAPCOMP_B];
  wire ccpDReq = flags3Bus.value[BIT_CAPCOMP_D] & enable3[BIT_CAPCOMP_D];
  wire ccpCReq = flags3Bus.value[BIT_CAPCOMP_C] & enable3[BIT_CAPCOMP_C];
  wire tmrFReq = flags3Bus.value[BIT_TIMER_F_MATCH] & enable3[BIT_TIMER_F_MATCH];
  wire tmrDReq = flags3Bus.value[BIT_TIMER_D_MATCH] & enable3[BIT_TIMER_D_MATCH];

  wire anySource = oscFailReq | compBReq | compAReq | nvmReq | collReq | ccpBReq
    | ccpDReq | ccpCReq | tmrFReq | tmrDReq;
  wire groupOn = globalCtl[BIT_PERIPH_GROUP_IRQ_EN];
  wire globalOn = globalCtl[BIT_GLOBAL_IRQ_EN];
  wire next_periphIrqReq = anySource & groupOn & globalOn;

  // Software should clear a stale flag before it sets the matching enable bit.
  logic reqQ;

  always_ff @(posedge mclk) begin
    if (rst) begin
      reqQ <= 1'b0;
    end else begin
      reqQ <= next_periphIrqReq;
    end
  end

  assign periphIrqReq = reqQ;

  // ----------------------------------------------------------------
  // Event status and interrupt line
  // ----------------------------------------------------------------
  flag_bus_if #(.W(EVT_W)) evtBus ();
  wire newFlag = |((sourceEvents2 & MASK_BANK_2 & ~flags2Bus.value)
    | (sourceEvents3 & MASK_BANK_3 & ~flags3Bus.value));

  assign evtBus.set = {next_periphIrqReq & ~reqQ, newFlag};
  assign evtBus.wr = wrEvtClear;
  assign evtBus.wrData = wrByte[EVT_W-1:0];

  sticky_flag_bank #(.W(EVT_W), .RESET_VALUE(RESET_EVT), .CLEAR_ON_ONE(1'b1)) evtStatus (
    .mclk(mclk),
    .rst(rst),
    .fb(evtBus.bank)
  );

  assign irq = |(evtBus.value & evtEnable);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [REG_W-1:0] rdByte;

  always_comb begin
    rdByte = 8'h00;
    if (hit(adr_i, OFS_ENABLE_2)) begin
      rdByte = enable2;
    end else if (hit(adr_i, OFS_ENABLE_3)) begin
      rdByte = enable3;
    end else if (hit(adr_i, OFS_FLAGS_2)) begin
      rdByte = flags2Bus.value;
    end else if (hit(adr_i, OFS_FLAGS_3)) begin
      rdByte = flags3Bus.value;
    end else if (hit(adr_i, OFS_GLOBAL_CTL)) begin
      rdByte = globalCtl;
    end else if (hit(adr_i, OFS_EVT_STATUS)) begin
      rdByte = {6'h00, evtBus.value};
    end else if (hit(adr_i, OFS_EVT_ENABLE)) begin
      rdByte = {6'h00, evtEnable};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dat_o <= 32'h0000_0000;
    end else if (take) begin
      dat_o <= {24'h00_0000, rdByte};
    end
  end
endmodule : peripheral_irq_enable_bank

// ==== bench/irq_bank_monitor.sv ====
// Port checks for the peripheral interrupt enable bank.
`timescale 1ns/10ps
module irq_bank_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [irq_bank_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [irq_bank_pkg::DAT_W-1:0] dat_i,
  input wire logic [irq_bank_pkg::DAT_W-1:0] dat_o,
  input wire logic ack_o,
  input wire logic periphIrqReq,
  input wire logic irq
);
  import irq_bank_pkg::*;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  wire take = cyc_i && stb_i && !ack_o;
  wire rdHit = take && !we_i;
  logic [1:0] ctl;
  logic rd2;
  logic rd3;
  always_ff @(posedge mclk) rd2 <= !rst && rdHit && adr_i[7:2] == OFS_ENABLE_2[7:2];
  always_ff @(posedge mclk) rd3 <= !rst && rdHit && adr_i[7:2] == OFS_ENABLE_3[7:2];
  always_ff @(posedge mclk) ctl <= rst ? 2'h0 :
    (take && we_i && sel_i[0] && adr_i[7:2] == OFS_GLOBAL_CTL[7:2]) ? dat_i[7:6] : ctl;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence answer_s; ack_o ##1 !ack_o; endsequence
  a_ack_answer: assert property (take |=> answer_s)
    else $error("request not answered by a single ack");
  a_ack_cause: assert property (ack_o |-> $past(take))
    else $error("ack without a taken request");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_bank2_gaps: assert property (ack_o && rd2 |-> (dat_o[7:0] & ~MASK_BANK_2) == 8'h0)
    else $error("enable 2 gap bits not zero");
  a_bank3_gaps: assert property (ack_o && rd3 |-> (dat_o[7:0] & ~MASK_BANK_3) == 8'h0)
    else $error("enable 3 gap bits not zero");
  a_group_gate: assert property (periphIrqReq |-> $past(ctl) == 2'h3)
    else $error("request without group and global enable");
  a_data_hold: assert property (!$past(take) |-> $stable(dat_o))
    else $error("read data changed without a request");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !periphIrqReq && !irq && !ack_o)
    else $error("outputs not cleared by reset");
endmodule : irq_bank_monitor
bind peripheral_irq_enable_bank irq_bank_monitor mon (.mclk(mclk), .rst(rst), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .periphIrqReq(periphIrqReq), .irq(irq));

// ==== bench/source_model.sv ====
// Peripheral condition sources that pulse one bank for one cycle on command.
`timescale 1ns/10ps
module source_model (
  input wire logic mclk,
  input wire logic fire,
  input wire logic bank,
  input wire logic [7:0] bits,
  output logic [7:0] sourceEvents2,
  output logic [7:0] sourceEvents3
);
  // ------------------------------------------------------------
  // Pulses
  // ------------------------------------------------------------
  always_ff @(posedge mclk) sourceEvents2 <= (fire && !bank) ? bits : 8'h00;
  always_ff @(posedge mclk) sourceEvents3 <= (fire && bank) ? bits : 8'h00;
endmodule : source_model

// ==== bench/tb_peripheral_irq_enable_bank.sv ====
// Self-checking bench for the peripheral interrupt enable bank.
`timescale 1ns/10ps
module tb_peripheral_irq_enable_bank;
  import irq_bank_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, fire = 1'b0, bank = 1'b0;
  logic [3:0] sel_i = 4'h0;
  logic [3:0] busSel = 4'h1;
  logic [7:0] adr_i = 8'h00, bits = 8'h00, m, v, ea, fa;
  logic [31:0] dat_i = 32'h0, dat_o, r;
  logic ack_o, periphIrqReq, irq;
  logic [7:0] sourceEvents2, sourceEvents3;
  logic [9:0] expQ[$];
  logic [7:0] ofs[9] = '{OFS_ENABLE_2, OFS_ENABLE_3, OFS_FLAGS_2, OFS_FLAGS_3, OFS_GLOBAL_CTL,
    OFS_EVT_STATUS, OFS_EVT_CLEAR, OFS_EVT_ENABLE, 8'h40};
  int fails = 0;
  int checks = 0;
  int seed = 56;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  initial forever #2 mclk = ~mclk;
  peripheral_irq_enable_bank uut (.mclk(mclk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sourceEvents2(sourceEvents2), .sourceEvents3(sourceEvents3),
    .periphIrqReq(periphIrqReq), .irq(irq));
  source_model src (.mclk(mclk), .fire(fire), .bank(bank), .bits(bits),
    .sourceEvents2(sourceEvents2), .sourceEvents3(sourceEvents3));
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [9:0] e);
    if (!w) expQ.push_back(e);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, busSel, a, 24'h0, d};
    do @(posedge mclk); while (ack_o !== 1'b1);
    {cyc_i, stb_i} <= 2'b00;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 10'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    bus(1'b0, a, 8'h0, e);
  endtask : rd
  task automatic pulse(input logic b, input logic [7:0] x);
    {fire, bank, bits} <= {1'b1, b, x};
    @(posedge mclk);
    fire <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : pulse
  always @(posedge mclk) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      check("read", {irq, periphIrqReq, dat_o[7:0]}, expQ.pop_front());
    end
  end
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    wr(OFS_EVT_STATUS, 8'hff);
    foreach (ofs[i]) rd(ofs[i], 10'h0);
    repeat (3) begin
      r = $random(seed);
      wr(OFS_ENABLE_2, r[7:0]);
      wr(OFS_ENABLE_3, r[15:8]);
      rd(OFS_ENABLE_2, {2'b00, r[7:0] & MASK_BANK_2});
      rd(OFS_ENABLE_3, {2'b00, r[15:8] & MASK_BANK_3});
    end
    busSel = 4'h2;
    wr(OFS_ENABLE_2, 8'hff);
    busSel = 4'h1;
    rd(OFS_ENABLE_2, {2'b00, r[7:0] & MASK_BANK_2});
    wr(OFS_ENABLE_3, 8'h00);
    wr(OFS_GLOBAL_CTL, 8'h80);
    wr(OFS_ENABLE_2, MASK_BANK_2);
    pulse(1'b0, 8'hff);
    rd(OFS_FLAGS_2, {2'b00, MASK_BANK_2});
    wr(OFS_GLOBAL_CTL, 8'h40);
    rd(OFS_FLAGS_2, {2'b00, MASK_BANK_2});
    wr(OFS_GLOBAL_CTL, 8'hc0);
    rd(OFS_FLAGS_2, {2'b01, MASK_BANK_2});
    wr(OFS_ENABLE_2, 8'h00);
    for (int i = 0; i < 16; i++) begin
      m = i[3] ? MASK_BANK_3 : MASK_BANK_2;
      ea = i[3] ? OFS_ENABLE_3 : OFS_ENABLE_2;
      fa = i[3] ? OFS_FLAGS_3 : OFS_FLAGS_2;
      v = 8'h01 << i[2:0];
      if ((m & v) != 8'h00) begin
        wr(OFS_FLAGS_2, 8'h00);
        wr(OFS_FLAGS_3, 8'h00);
        wr(ea, m & ~v);
        pulse(i[3], v);
        rd(fa, {2'b00, v});
        wr(fa, 8'h00);
        wr(ea, v);
        pulse(i[3], v);
        rd(fa, {2'b01, v});
        wr(ea, 8'h00);
      end
    end
    rd(OFS_EVT_STATUS, 10'h003);
    wr(OFS_EVT_ENABLE, 8'h02);
    rd(OFS_EVT_STATUS, 10'h203);
    wr(OFS_GLOBAL_CTL, 8'h00);
    wr(OFS_EVT_CLEAR, 8'h03);
    wr(OFS_EVT_ENABLE, 8'h01);
    pulse(1'b1, 8'h02);
    rd(OFS_EVT_STATUS, 10'h201);
    wr(OFS_EVT_ENABLE, 8'h00);
    rd(OFS_EVT_STATUS, 10'h001);
    wr(OFS_EVT_CLEAR, 8'h01);
    rd(OFS_EVT_STATUS, 10'h000);
    wr(OFS_ENABLE_2, 8'hff);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(OFS_ENABLE_2, 10'h0);
    report_and_stop();
  end
endmodule : tb_peripheral_irq_enable_bank
